// File: shared/ftx_regs.svh
// constants for the transmit symbol coder: code groups, widths, timing
`ifndef FTX_REGS_SVH
`define FTX_REGS_SVH
`define FTX_GRP_IDLE   5'h1F
`define FTX_GRP_SSD1   5'h18
`define FTX_GRP_SSD2   5'h11
`define FTX_GRP_ESD1   5'h0D
`define FTX_GRP_ESD2   5'h07
`define FTX_GRP_ERR    5'h04
`define FTX_SEED       11'h7FF
`define FTX_TAP_HI     10
`define FTX_TAP_LO     8
`define FTX_BIT_LAST   3'h4
`define FTX_FIFO_DEPTH 32
`define FTX_FIFO_WIDTH 6
`define FTX_CLK_MHZ    125
`endif

// File: shared/ftx_pkg.sv
// types shared by the transmit symbol coder
package ftx_pkg;
  // one nibble from the internal mii with its error flag
  typedef struct packed {
    logic       err;
    logic       enable;
    logic [3:0] data;
  } ftx_nib_t;
  // three level line state
  typedef enum logic [1:0] {
    FTX_LVL_ZERO = 2'h0,
    FTX_LVL_POS  = 2'h1,
    FTX_LVL_NEG  = 2'h3
  } ftx_lvl_t;
  // encoder frame sequence, gray coded along the usual path
  typedef enum logic [2:0] {
    FTX_S_IDLE = 3'h0,
    FTX_S_SSD2 = 3'h1,
    FTX_S_DATA = 3'h3,
    FTX_S_ESD2 = 3'h2
  } ftx_state_t;
endpackage

// File: core/ftx_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module ftx_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // honest full and empty from the occupancy count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;

  // storage written by index
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end

  a_fifo_no_over: assert property (@(posedge core_clk) disable iff (!nrst)
    count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// File: core/ftx_mlt3.sv
// nrzi bit stream to three level line code
`timescale 1ns/1ns
module ftx_mlt3
  import ftx_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  // code bit in
  input  wire logic code_bit,
  input  wire logic bit_valid,
  // line level out
  output ftx_lvl_t  level
);
  ftx_lvl_t next_level;
  logic     last_nonzero_pos;

  // a one steps 0,+,0,-; a zero holds the level
  always_comb begin
    next_level = level;
    if (bit_valid && code_bit) begin
      unique case (level)
        FTX_LVL_ZERO: next_level = last_nonzero_pos ? FTX_LVL_NEG : FTX_LVL_POS;
        FTX_LVL_POS:  next_level = FTX_LVL_ZERO;
        FTX_LVL_NEG:  next_level = FTX_LVL_ZERO;
        default:      next_level = FTX_LVL_ZERO;
      endcase
    end
  end

  // level register and memory of last excursion
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level            <= FTX_LVL_ZERO;
      last_nonzero_pos <= 1'b0;
    end else if (clk_en) begin
      level <= next_level;
      if (next_level == FTX_LVL_POS) begin
        last_nonzero_pos <= 1'b1;
      end else if (next_level == FTX_LVL_NEG) begin
        last_nonzero_pos <= 1'b0;
      end
    end
  end

  a_mlt3_zero_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && bit_valid && !code_bit) |=> $stable(level)) else $error("level moved on zero");
  a_mlt3_one_step: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && bit_valid && code_bit) |=> !$stable(level)) else $error("level held on one");
endmodule

// File: core/ftx_encoder.sv
// 100 Mb/s transmit path: 4b/5b coding, scrambling, serialising, mlt-3
`timescale 1ns/1ns
`include "ftx_regs.svh"

// Summary of operation
// - each data nibble is mapped to its fixed 5-bit data code group.
// - between frames the idle group 11111 is sent continuously after the end delimiter.
// - a rising transmit enable sends group 11000 then 10001 in place of the first two preamble nibbles.
// - a falling transmit enable sends group 01101 then 00111 and then returns to idle.
// - while the error input is high in a frame the error group 00100 replaces the data group.
// - none of the ten invalid code groups is ever produced by normal coding.
// - a low coding-enable control bypasses the coding and a high one restores it.
// - in bypass the four data bits form the low group bits and the error input the top bit.
// - the serialiser turns parallel groups into serial bits and the scrambler whitens that bit stream.
// - the serial bits leave at one code bit per 125 MHz clock.
// - the three-level output steps for each one bit and holds for each zero bit.
// - all transmit symbol logic runs from the single 125 MHz core clock.
module ftx_encoder
  import ftx_pkg::*;
(
  // clock, reset, enable
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  // internal mii transmit side, one nibble per valid beat
  input  wire logic [3:0] tx_data,
  input  wire logic       tx_enable,
  input  wire logic       tx_error,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // control: low bypasses 4b/5b coding
  input  wire logic       coding_en,
  // line side
  output ftx_lvl_t        line_level,
  output logic            line_bit,
  output logic            line_bit_valid
);
  // two flop synchroniser for the static control pin
  logic coding_en_s1;
  logic coding_en_s2;

  // fifo ports
  ftx_nib_t fifo_in;
  ftx_nib_t fifo_out;
  logic     fifo_out_valid;
  logic     fifo_out_ready;
  logic     fifo_in_ready;

  // coder state
  ftx_state_t state;
  ftx_state_t next_state;
  logic [4:0] next_group;

  // serialiser
  logic [4:0]  shift;
  logic [2:0]  bit_cnt;
  logic        load;
  logic [10:0] key;
  logic        ser_bit;
  logic        ser_valid;
  logic        out_bit;
  logic        out_valid;
  ftx_lvl_t    mlt_level;

  // fixed 4b/5b table for data nibbles
  function automatic logic [4:0] ftx_code(input logic [3:0] nib);
    logic [4:0] g;
    g = `FTX_GRP_IDLE;
    unique case (nib)
      4'h0: g = 5'h1E;
      4'h1: g = 5'h09;
      4'h2: g = 5'h14;
      4'h3: g = 5'h15;
      4'h4: g = 5'h0A;
      4'h5: g = 5'h0B;
      4'h6: g = 5'h0E;
      4'h7: g = 5'h0F;
      4'h8: g = 5'h12;
      4'h9: g = 5'h13;
      4'hA: g = 5'h16;
      4'hB: g = 5'h17;
      4'hC: g = 5'h1A;
      4'hD: g = 5'h1B;
      4'hE: g = 5'h1C;
      4'hF: g = 5'h1D;
    endcase
    return g;
  endfunction

  // the coding-enable pin comes from outside, synchronise before use
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      coding_en_s1 <= 1'b1;
      coding_en_s2 <= 1'b1;
    end else if (clk_en) begin
      coding_en_s1 <= coding_en;
      coding_en_s2 <= coding_en_s1;
    end
  end

  // the fifo absorbs the mii nibble rate against the group rate; a nibble is
  // only taken while ready is shown, so a held offer is never stored twice
  assign fifo_in  = '{err: tx_error, enable: tx_enable, data: tx_data};
  ftx_fifo #(
    .WIDTH (`FTX_FIFO_WIDTH),
    .DEPTH (`FTX_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (tx_valid && tx_ready),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // ready registered so the output comes from a flop; ready drops for a cycle
  // after every take because the registered view lags the true level by a cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
    end else if (clk_en) begin
      tx_ready <= fifo_in_ready && !(tx_valid && tx_ready);
    end
  end

  // a group is taken from the fifo only when the serialiser reloads. the
  // start pair stands in place of the first two preamble nibbles: the idle
  // slot that sends the first half drops the first nibble, the second half
  // drops the next one; a nibble without the frame flag is dropped in idle.
  // limitation: a second preamble nibble that arrives late is sent as data
  assign load           = (bit_cnt == `FTX_BIT_LAST);
  assign fifo_out_ready = load && (state == FTX_S_DATA || state == FTX_S_IDLE
                                   || (state == FTX_S_SSD2 && fifo_out.enable));

  // group selection for the next five bit slot
  always_comb begin
    next_state = state;
    next_group = `FTX_GRP_IDLE;
    unique case (state)
      FTX_S_IDLE: begin
        if (fifo_out_valid && fifo_out.enable) begin
          next_group = `FTX_GRP_SSD1;
          next_state = FTX_S_SSD2;
        end
      end
      FTX_S_SSD2: begin
        next_group = `FTX_GRP_SSD2;
        next_state = FTX_S_DATA;
      end
      FTX_S_DATA: begin
        if (!fifo_out_valid || !fifo_out.enable) begin
          next_group = `FTX_GRP_ESD1;
          next_state = FTX_S_ESD2;
        end else if (!coding_en_s2) begin
          next_group = {fifo_out.err, fifo_out.data};
        end else if (fifo_out.err) begin
          next_group = `FTX_GRP_ERR;
        end else begin
          next_group = ftx_code(fifo_out.data);
        end
      end
      FTX_S_ESD2: begin
        next_group = `FTX_GRP_ESD2;
        next_state = FTX_S_IDLE;
      end
      default: begin
        next_state = FTX_S_IDLE;
      end
    endcase
  end

  // frame sequence advances once per five bit slot
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= FTX_S_IDLE;
    end else if (clk_en && load) begin
      state <= next_state;
    end
  end

  // parallel in serial out, msb first, one bit per core clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift   <= `FTX_GRP_IDLE;
      bit_cnt <= 3'h0;
    end else if (clk_en) begin
      if (load) begin
        shift   <= next_group;
        bit_cnt <= 3'h0;
      end else begin
        shift   <= {shift[3:0], 1'b0};
        bit_cnt <= 3'(bit_cnt + 1'b1);
      end
    end
  end

  // free-running key, advanced every bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      key <= `FTX_SEED;
    end else if (clk_en) begin
      key <= {key[9:0], key[`FTX_TAP_HI] ^ key[`FTX_TAP_LO]};
    end
  end

  // whitened code bit, one per clock
  assign ser_bit   = shift[4] ^ key[`FTX_TAP_HI] ^ key[`FTX_TAP_LO];
  assign ser_valid = 1'b1;

  // registered serial output, every clock carries a bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_bit   <= 1'b0;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      out_bit   <= ser_bit;
      out_valid <= ser_valid;
    end
  end

  // three level line coder, clocked by the same 125 MHz core clock
  ftx_mlt3 u_mlt3 (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .code_bit  (out_bit),
    .bit_valid (out_valid),
    .level     (mlt_level)
  );

  // outputs straight from flops; level already registered in the child,
  // both retimed by one flop, so the level still trails the bit that produced it by one clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      line_level     <= FTX_LVL_ZERO;
      line_bit       <= 1'b0;
      line_bit_valid <= 1'b0;
    end else if (clk_en) begin
      line_level     <= mlt_level;
      line_bit       <= out_bit;
      line_bit_valid <= out_valid;
    end
  end

  // delimiter and group checks, one group decision per slot
  a_ssd_pair_order: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_IDLE && next_state == FTX_S_SSD2) |=>
    (shift == `FTX_GRP_SSD1)) else $error("ssd first group wrong");
  a_ssd_second: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_SSD2) |=> (shift == `FTX_GRP_SSD2)) else $error("ssd second group wrong");
  a_esd_then_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_ESD2) |=> (shift == `FTX_GRP_ESD2) && (state == FTX_S_IDLE))
    else $error("esd second group or return wrong");
  a_idle_fill: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_IDLE && next_state == FTX_S_IDLE) |=> (shift == `FTX_GRP_IDLE))
    else $error("idle group not sent");
  a_error_group: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_DATA && fifo_out_valid && fifo_out.enable && fifo_out.err
     && coding_en_s2) |=> (shift == `FTX_GRP_ERR)) else $error("error group missing");
  a_no_invalid_grp: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && coding_en_s2) |-> !(next_group inside {5'h06, 5'h19, 5'h00, 5'h01, 5'h02,
    5'h03, 5'h05, 5'h08, 5'h0C, 5'h10})) else $error("invalid group chosen");
  a_bypass_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_DATA && fifo_out_valid && fifo_out.enable && !coding_en_s2)
    |=> (shift == {$past(fifo_out.err), $past(fifo_out.data)})) else $error("bypass group wrong");
  a_slot_five_bits: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load) ##1 clk_en [*4] |=> load) else $error("group slot not five bits");
  a_key_nonzero: assert property (@(posedge core_clk) disable iff (!nrst)
    key != 11'h000) else $error("scrambler key stuck at zero");
  a_esd_on_end: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_DATA && (!fifo_out_valid || !fifo_out.enable))
    |=> (shift == `FTX_GRP_ESD1) && (state == FTX_S_ESD2)) else $error("esd first group missing");
  a_data_group: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && load && state == FTX_S_DATA && fifo_out_valid && fifo_out.enable && !fifo_out.err
     && coding_en_s2) |=> (shift == ftx_code($past(fifo_out.data)))) else $error("data group wrong");

  // serial path and handshake checks; a frozen clock enable must not move anything
  a_msb_first: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && !load) |=> (shift == {$past(shift[3:0]), 1'b0})) else $error("shift order wrong");
  a_key_step: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> (key == {$past(key[9:0]), $past(key[`FTX_TAP_HI] ^ key[`FTX_TAP_LO])})) else $error("key step wrong");
  a_line_retime: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> (line_bit == $past(out_bit))) else $error("line bit not retimed");
  a_level_retime: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> (line_level == $past(mlt_level))) else $error("line level not retimed");
  a_ready_gap: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && tx_valid && tx_ready) |=> !tx_ready) else $error("ready held after a take");

  // scenarios worth seeing at least once
  c_frame_start: cover property (@(posedge core_clk) disable iff (!nrst) state == FTX_S_SSD2);
  c_frame_end: cover property (@(posedge core_clk) disable iff (!nrst) state == FTX_S_ESD2);
  c_bypass_data: cover property (@(posedge core_clk) disable iff (!nrst)
    state == FTX_S_DATA && !coding_en_s2 && load);
  c_fifo_full: cover property (@(posedge core_clk) disable iff (!nrst) !fifo_in_ready);
  c_error_slot: cover property (@(posedge core_clk) disable iff (!nrst)
    state == FTX_S_DATA && load && fifo_out_valid && fifo_out.err && coding_en_s2);
endmodule

// File: sim/ftx_mac_model.sv
// behavioural mac feeding nibbles over the internal mii
`timescale 1ns/1ns
module ftx_mac_model
  import ftx_pkg::*;
(
  // clock and pacing
  input  wire logic       core_clk,
  input  wire logic       slow,
  // mii transmit side
  input  wire logic       tx_ready,
  output logic      [3:0] tx_data,
  output logic            tx_enable,
  output logic            tx_error,
  output logic            tx_valid
);
  // quiet bus at time zero
  initial begin
    tx_valid  = 1'b0;
    tx_enable = 1'b0;
    tx_error  = 1'b0;
    tx_data   = 4'hA;
  end
  // offer one nibble and hold it until the edge that takes it; caller stands at a falling edge
  task automatic send(input ftx_nib_t n);
    int gap;
    gap = slow ? $urandom_range(2) : 0;
    if (gap > 0) begin
      tx_valid = 1'b0;
      tx_data  = ~tx_data; // stale data must not look like a held nibble
      repeat (gap) @(negedge core_clk);
    end
    {tx_error, tx_enable, tx_data} = n;
    tx_valid = 1'b1;
    do @(posedge core_clk); while (tx_ready !== 1'b1);
    @(negedge core_clk);
  endtask
  // let go of the bus between frames
  task automatic release_bus;
    tx_valid  = 1'b0;
    tx_enable = 1'b0;
    tx_data   = ~tx_data;
  endtask
endmodule

// File: sim/fast_ethernet_tx_symbol_encoder_tb_top.sv
// self-checking bench: mac model in, line stream descrambled and parsed out
`timescale 1ns/1ns
module fast_ethernet_tx_symbol_encoder_tb_top;
  import ftx_pkg::*;
  logic       core_clk, nrst, clk_en, coding_en, slow;
  logic [3:0] tx_data;
  logic       tx_enable, tx_error, tx_valid, tx_ready, line_bit, line_bit_valid;
  ftx_lvl_t   line_level, lvl_prev, last_nz, exp_lvl, sl;
  int         bad_count, comparisons, nlearn, zeros, nb, left, low_run, max_low;
  logic [10:0] kh;
  logic [9:0] win;
  logic [4:0] g, eg;
  logic       k, d, in_frame, byp, ce_d, sb;
  logic [4:0] exp_q[$];
  logic [8:0] len_q[$];
  logic       bq[$], cq[$];
  logic [4:0] enc_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                               5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [31:0] INV_MASK = 32'h0201116F; // the ten unused code groups

  ftx_encoder DUT (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .tx_data(tx_data),
    .tx_enable(tx_enable), .tx_error(tx_error), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .coding_en(coding_en), .line_level(line_level), .line_bit(line_bit), .line_bit_valid(line_bit_valid));
  ftx_mac_model mac (.core_clk(core_clk), .slow(slow), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_enable(tx_enable), .tx_error(tx_error), .tx_valid(tx_valid));

  // 20 MHz bench clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // line monitor: learns the key from idle, then descrambles and frames on the start pair
  always @(posedge core_clk) begin
    if (ce_d && line_bit_valid === 1'b1) begin
      if (line_level !== lvl_prev) begin
        exp_lvl = (lvl_prev != FTX_LVL_ZERO) ? FTX_LVL_ZERO : (last_nz == FTX_LVL_POS ? FTX_LVL_NEG : FTX_LVL_POS);
        chk({6'h00, line_level}, {6'h00, exp_lvl});
        if (lvl_prev != FTX_LVL_ZERO) last_nz = lvl_prev;
      end
      bq.push_back(line_bit);
      cq.push_back(line_level !== lvl_prev);
      lvl_prev = line_level;
      if (nlearn < 11) begin
        kh = {kh[9:0], ~line_bit}; // idle sends all ones, so the line bit exposes the key
        nlearn++;
      end else begin
        k  = kh[10] ^ kh[8];
        kh = {kh[9:0], k};
        d  = line_bit ^ k;
        if (!in_frame) begin
          win = {win[8:0], d};
          zeros += (d == 1'b0);
          if (win == 10'h311) begin
            chk(8'(zeros), 8'd6);
            in_frame = 1'b1;
            zeros = 0;
            nb = 0;
            if (len_q.size() == 0) chk(8'h00, 8'hFF);
            else begin
              byp  = len_q[0][8];
              left = int'(len_q[0][7:0]);
              void'(len_q.pop_front());
            end
          end
        end else begin
          g = {g[3:0], d};
          nb++;
          if (nb == 5) begin
            eg = (exp_q.size() != 0) ? exp_q.pop_front() : 5'h1F;
            chk({3'h0, g}, {3'h0, eg});
            if (!byp && INV_MASK[g]) chk({3'h0, g}, 8'hFF);
            nb = 0;
            left--;
            if (left == 0) begin
              in_frame = 1'b0;
              win = 10'h3FF;
            end
          end
        end
      end
    end
    ce_d = clk_en;
    low_run = (tx_valid && tx_ready === 1'b0) ? low_run + 1 : 0;
    if (low_run > max_low) max_low = low_run;
  end

  // one frame: n nibbles, error flag on two nibbles from errpos, seq walks all data values;
  // the start pair replaces the first two nibbles, so n-2 data groups then the end pair follow it
  task automatic frame(input int n, input int errpos, input logic bp, input logic seq);
    ftx_nib_t nib;
    int i;
    len_q.push_back({bp, 8'(n < 2 ? 2 : n)});
    for (i = 0; i < n; i++) begin
      nib.data   = seq ? 4'(i) : 4'($urandom);
      nib.enable = 1'b1;
      nib.err    = (i >= errpos && i < errpos + 2);
      if (i >= 2) exp_q.push_back(bp ? {nib.err, nib.data} : (nib.err ? 5'h04 : enc_tab[nib.data]));
      mac.send(nib);
    end
    exp_q.push_back(5'h0D);
    exp_q.push_back(5'h07);
    nib = '0; // a nibble without the frame flag closes the frame
    mac.send(nib);
    mac.release_bus();
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge core_clk);
    repeat (30) @(negedge core_clk);
    $display("frame of %0d nibbles done, bypass=%0d", n, bp);
  endtask

  initial begin
    int lag, i;
    logic ok, found;
    nrst = 1'b0; clk_en = 1'b1; coding_en = 1'b1; slow = 1'b0;
    bad_count = 0; comparisons = 0; nlearn = 0; zeros = 0; nb = 0; left = 0;
    low_run = 0; max_low = 0; kh = '0; win = 10'h3FF; g = '0;
    in_frame = 1'b0; byp = 1'b0; ce_d = 1'b0; lvl_prev = FTX_LVL_ZERO; last_nz = FTX_LVL_NEG;
    void'($urandom(47495));
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    repeat (40) @(negedge core_clk);
    frame(18, 99, 1'b0, 1'b1);
    slow = 1'b1;
    frame(24, 5, 1'b0, 1'b0);
    slow = 1'b0;
    frame(3, 2, 1'b0, 1'b0);
    frame(100, 99, 1'b0, 1'b0);
    chk(8'(max_low > 2), 8'h01);
    coding_en = 1'b0;
    repeat (10) @(negedge core_clk);
    frame(20, 3, 1'b1, 1'b0);
    coding_en = 1'b1;
    repeat (10) @(negedge core_clk);
    frame(8, 6, 1'b0, 1'b0);
    // freeze: line level and line bit must hold while the enable is low
    clk_en = 1'b0;
    sl = line_level;
    sb = line_bit;
    repeat (7) @(negedge core_clk);
    chk({5'h00, sb, sl}, {5'h00, line_bit, line_level});
    clk_en = 1'b1;
    repeat (40) @(negedge core_clk);
    $display("freeze test done");
    // each level step must line up with a one bit at some fixed pipeline lag
    found = 1'b0;
    for (lag = 0; lag < 4; lag++) begin
      ok = 1'b1;
      for (i = 0; i + lag < bq.size(); i++)
        if (cq[i + lag] !== bq[i]) ok = 1'b0;
      if (ok) found = 1'b1;
    end
    chk(8'(found), 8'h01);
    chk(8'(exp_q.size()), 8'h00);
    $display("alignment and drain checks done");
    test_done();
  end

  // watchdog well beyond the expected run of a little over a thousand cycles
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule
